/* File: irc_sel.sv */
// Internal RC clock source selection, trim and low-power RC keep-alive
`timescale 1ns/1ns
// What this block does
// - Code 001 selects fast RC system clock
// - Four-bit writable trim, 1.5 percent steps
// - Trim is two's complement, zero is centre
// - Code 111 plus modes 5-7 give x4/x8/x16
// - Low-power RC clocks timers and monitors
// - Power-on reset forces low-power RC on
// - After timer, keep-alive conditions hold it on
// - No keep-alive at expiry switches it off
// - Second pin function follows primary mode only
// - First pin never released for general I/O
module irc_sel (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_por_event,
  input  wire logic                      i_pwrup_expired,
  input  wire logic                      i_fail_monitor_en,
  input  wire logic                      i_watchdog_en,
  input  wire logic [2:0]                i_current_clock_source_sel,
  input  wire logic [4:0]                i_primary_mode_config,
  input  wire logic                      i_trim_wr,
  input  wire logic [irc_pkg::TRIM_W-1:0] i_trim_wdata,
  output logic                           o_sysclk_from_fast_rc,
  output logic                           o_pll_en,
  output logic [4:0]                     o_pll_mult,
  output logic [irc_pkg::TRIM_W-1:0]     o_rc_trim_reg,
  output logic signed [7:0]              o_trim_offset_permil,
  output logic                           o_x16_trim_too_high,
  output logic                           o_low_power_internal_rc_en,
  output logic                           o_timers_on_low_power_rc,
  output logic [4:0]                     o_osc_pin_two_mode,
  output logic                           o_osc_pin_one_gpio_en
);
  import irc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The trim helpers below are written for a four-bit code only
  if (TRIM_W != 4) begin : g_trim_width_check
    $error("trim field must be four bits wide");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] pll_mult_of(input logic [2:0] sel, input logic [4:0] pm);
    logic [4:0] m;
    m = PLL_MULT_NONE;
    if (sel == SEL_PRIMARY_PLL) begin
      if (pm == PM_FAST_RC_X4) begin
        m = PLL_MULT_X4;
      end else if (pm == PM_FAST_RC_X8) begin
        m = PLL_MULT_X8;
      end else if (pm == PM_FAST_RC_X16) begin
        m = PLL_MULT_X16;
      end
    end
    return m;
  endfunction : pll_mult_of

  // Two's complement trim code times the step, in tenths of a percent
  function automatic logic signed [7:0] trim_permil(input logic [3:0] code);
    logic signed [7:0] s;
    s = 8'(signed'(code));
    return 8'(int'(s) * TRIM_STEP_PERMIL);
  endfunction : trim_permil

  // Frequency estimate only; the real step is uncharacterised
  function automatic logic trim_exceeds_x16(input logic [3:0] code);
    int f_khz;
    f_khz = FAST_RC_NOM_KHZ * (1000 + int'(trim_permil(code))) / 1000;
    return (f_khz > X16_LIMIT_KHZ);
  endfunction : trim_exceeds_x16

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    irc_lp_state_t     lp_state;
    logic [3:0]        trim;
    logic              fast_rc_sel;
    logic              pll_en;
    logic [4:0]        pll_mult;
    logic signed [7:0] trim_off;
    logic              x16_high;
    logic              lp_rc_en;
    logic [4:0]        pin_two_mode;
  } irc_state_t;

  irc_state_t st;
  irc_state_t next_st;
  logic       keep_alive;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    keep_alive = i_fail_monitor_en | i_watchdog_en
               | (i_current_clock_source_sel == SEL_LOW_POWER_RC);
    next_st.fast_rc_sel = (i_current_clock_source_sel == SEL_FAST_RC);
    next_st.pll_mult = pll_mult_of(i_current_clock_source_sel, i_primary_mode_config);
    next_st.pll_en = (next_st.pll_mult != PLL_MULT_NONE);
    if (i_trim_wr) begin
      next_st.trim = i_trim_wdata;
    end
    next_st.trim_off = trim_permil(next_st.trim);
    // Flag only; keeping the x16 input in range is up to software
    next_st.x16_high = (next_st.pll_mult == PLL_MULT_X16) & trim_exceeds_x16(next_st.trim);
    // Pin two follows the primary mode alone, never the runtime selection
    next_st.pin_two_mode = i_primary_mode_config;
    case (st.lp_state)
      LP_POR_HOLD: begin
        next_st.lp_rc_en = 1'b1;
        if (i_pwrup_expired) begin
          next_st.lp_state = LP_RUN;
          next_st.lp_rc_en = keep_alive;
        end
      end
      LP_RUN: begin
        next_st.lp_rc_en = keep_alive;
      end
      default: begin
        next_st.lp_state = LP_POR_HOLD;
        next_st.lp_rc_en = 1'b1;
      end
    endcase
    // A power-on event outranks a trim write landing in the same cycle
    if (i_por_event) begin
      next_st.lp_state = LP_POR_HOLD;
      next_st.lp_rc_en = 1'b1;
      next_st.trim = TRIM_RESET;
      next_st.trim_off = 8'sh00;
      next_st.x16_high = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st.lp_state <= LP_POR_HOLD;
      st.trim <= TRIM_RESET;
      st.fast_rc_sel <= 1'b0;
      st.pll_en <= 1'b0;
      st.pll_mult <= PLL_MULT_NONE;
      st.trim_off <= 8'sh00;
      st.x16_high <= 1'b0;
      st.lp_rc_en <= 1'b1;
      st.pin_two_mode <= 5'h00;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sysclk_from_fast_rc = st.fast_rc_sel;
  assign o_pll_en              = st.pll_en;
  assign o_pll_mult            = st.pll_mult;
  assign o_rc_trim_reg         = st.trim;
  assign o_trim_offset_permil  = st.trim_off;
  assign o_x16_trim_too_high   = st.x16_high;
  assign o_low_power_internal_rc_en = st.lp_rc_en;
  // Timers and monitors always run from the low-power RC
  assign o_timers_on_low_power_rc = 1'b1;
  assign o_osc_pin_two_mode    = st.pin_two_mode;
  // Pin one stays with the oscillator, whatever source is selected
  assign o_osc_pin_one_gpio_en = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_fast_rc_sel;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ##1 (o_sysclk_from_fast_rc == ($past(i_current_clock_source_sel) == 3'h1));
  endproperty
  a_fast_rc_sel: assert property (p_fast_rc_sel) else $error("fast RC select wrong");

  property p_trim_write;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_trim_wr && !i_por_event) |=> (o_rc_trim_reg == $past(i_trim_wdata));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  property p_trim_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!i_trim_wr && !i_por_event) |=> $stable(o_rc_trim_reg);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");

  property p_trim_signed;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_rc_trim_reg == 4'h8) |-> (o_trim_offset_permil == 8'sh88);
  endproperty
  a_trim_signed: assert property (p_trim_signed) else $error("trim code 1000 not -12.0");

  property p_trim_top;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_rc_trim_reg == 4'h7) |-> (o_trim_offset_permil == 8'sh69);
  endproperty
  a_trim_top: assert property (p_trim_top) else $error("trim code 0111 not +10.5");

  property p_pll_x16;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_current_clock_source_sel == 3'h7 && i_primary_mode_config == 5'h07)
        |=> (o_pll_mult == 5'h10 && o_pll_en);
  endproperty
  a_pll_x16: assert property (p_pll_x16) else $error("x16 multiplier not applied");

  property p_pll_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_current_clock_source_sel != 3'h7) |=> (!o_pll_en && o_pll_mult == 5'h00);
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("PLL multiplier without code 111");

  property p_por_lp_rc;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_por_event |=> (o_low_power_internal_rc_en && o_rc_trim_reg == TRIM_RESET);
  endproperty
  a_por_lp_rc: assert property (p_por_lp_rc) else $error("power-on reset left RC off");

  property p_hold_until_expiry;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.lp_state == LP_POR_HOLD && !i_pwrup_expired) |=> o_low_power_internal_rc_en;
  endproperty
  a_hold_until_expiry: assert property (p_hold_until_expiry)
    else $error("low-power RC off before expiry");

  property p_keep_alive;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.lp_state == LP_RUN && !i_por_event && i_watchdog_en) |=> o_low_power_internal_rc_en;
  endproperty
  a_keep_alive: assert property (p_keep_alive) else $error("RC stopped with watchdog on");

  property p_expiry_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_pwrup_expired && !i_por_event && !i_watchdog_en && !i_fail_monitor_en
        && i_current_clock_source_sel != 3'h5) |=> !o_low_power_internal_rc_en;
  endproperty
  a_expiry_off: assert property (p_expiry_off) else $error("RC left on without need");

  property p_pin_two;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ##1 (o_osc_pin_two_mode == $past(i_primary_mode_config));
  endproperty
  a_pin_two: assert property (p_pin_two) else $error("pin two mode not from primary mode");

  property p_pin_one;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !o_osc_pin_one_gpio_en && o_timers_on_low_power_rc;
  endproperty
  a_pin_one: assert property (p_pin_one) else $error("pin one freed or timer clock moved");

  property p_pll_x4;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_current_clock_source_sel == SEL_PRIMARY_PLL && i_primary_mode_config == PM_FAST_RC_X4)
        |=> (o_pll_mult == PLL_MULT_X4 && o_pll_en);
  endproperty
  a_pll_x4: assert property (p_pll_x4) else $error("x4 multiplier not applied");

  property p_pll_x8;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_current_clock_source_sel == SEL_PRIMARY_PLL && i_primary_mode_config == PM_FAST_RC_X8)
        |=> (o_pll_mult == PLL_MULT_X8 && o_pll_en);
  endproperty
  a_pll_x8: assert property (p_pll_x8) else $error("x8 multiplier not applied");

  property p_keep_monitor;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.lp_state == LP_RUN && !i_por_event && i_fail_monitor_en)
        |=> o_low_power_internal_rc_en;
  endproperty
  a_keep_monitor: assert property (p_keep_monitor) else $error("RC off, monitor on");

  property p_keep_selected;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.lp_state == LP_RUN && !i_por_event && i_current_clock_source_sel == SEL_LOW_POWER_RC)
        |=> o_low_power_internal_rc_en;
  endproperty
  a_keep_selected: assert property (p_keep_selected) else $error("RC off while selected");

  property p_flag_needs_x16;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_x16_trim_too_high |-> (o_pll_mult == PLL_MULT_X16);
  endproperty
  a_flag_needs_x16: assert property (p_flag_needs_x16) else $error("trim flag without x16");

  property p_trim_centre;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_rc_trim_reg == TRIM_RESET) |-> (o_trim_offset_permil == 8'sh00);
  endproperty
  a_trim_centre: assert property (p_trim_centre) else $error("centre code not zero");

  property p_trim_minus_one;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_rc_trim_reg == 4'hf) |-> (o_trim_offset_permil == 8'shf1);
  endproperty
  a_trim_minus_one: assert property (p_trim_minus_one) else $error("code 1111 not -1.5");

  property p_por_trim;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_por_event && i_trim_wr) |=> (o_rc_trim_reg == TRIM_RESET);
  endproperty
  a_por_trim: assert property (p_por_trim) else $error("write beat power-on event");

  property p_fast_rc_no_pll;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_sysclk_from_fast_rc |-> !o_pll_en;
  endproperty
  a_fast_rc_no_pll: assert property (p_fast_rc_no_pll) else $error("fast RC with PLL");

endmodule : irc_sel

/* File: irc_pkg.sv */
// Constants for the internal RC clock selection block
package irc_pkg;
  // ----------------------------------------------------------------
  // Current clock source selection codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_FAST_RC      = 3'h1;
  localparam logic [2:0] SEL_PRIMARY_PLL  = 3'h7;
  localparam logic [2:0] SEL_LOW_POWER_RC = 3'h5;
  // ----------------------------------------------------------------
  // Primary mode configuration codes for the fast RC with PLL, and the multipliers they give
  // ----------------------------------------------------------------
  localparam logic [4:0] PM_FAST_RC_X4    = 5'h05;
  localparam logic [4:0] PM_FAST_RC_X8    = 5'h06;
  localparam logic [4:0] PM_FAST_RC_X16   = 5'h07;
  localparam logic [4:0] PLL_MULT_NONE    = 5'h00;
  localparam logic [4:0] PLL_MULT_X4      = 5'h04;
  localparam logic [4:0] PLL_MULT_X8      = 5'h08;
  localparam logic [4:0] PLL_MULT_X16     = 5'h10;
  // ----------------------------------------------------------------
  // Trim field
  // ----------------------------------------------------------------
  localparam int         TRIM_LSB         = 0;
  localparam int         TRIM_W           = 4;
  localparam logic [3:0] TRIM_RESET       = 4'h0;
  localparam int         TRIM_STEP_PERMIL = 15;
  localparam int         FAST_RC_NOM_KHZ  = 7370;
  localparam int         X16_LIMIT_KHZ    = 7500;
  // ----------------------------------------------------------------
  // Low-power RC sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LP_POR_HOLD = 2'b01,
    LP_RUN      = 2'b10
  } irc_lp_state_t;
endpackage : irc_pkg

/* File: irc_sel_tb.sv */
// Self-checking testbench for the internal RC clock selection block
`timescale 1ns/1ns
module tb;
  import irc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  i_core_clk = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic                  i_por_event = 1'b0;
  logic                  i_pwrup_expired = 1'b0;
  logic                  i_fail_monitor_en = 1'b0;
  logic                  i_watchdog_en = 1'b0;
  logic [2:0]            i_current_clock_source_sel = 3'h0;
  logic [4:0]            i_primary_mode_config = 5'h00;
  logic                  i_trim_wr = 1'b0;
  logic [TRIM_W-1:0]     i_trim_wdata = 4'h0;
  logic                  o_sysclk_from_fast_rc;
  logic                  o_pll_en;
  logic [4:0]            o_pll_mult;
  logic [TRIM_W-1:0]     o_rc_trim_reg;
  logic signed [7:0]     o_trim_offset_permil;
  logic                  o_x16_trim_too_high;
  logic                  o_low_power_internal_rc_en;
  logic                  o_timers_on_low_power_rc;
  logic [4:0]            o_osc_pin_two_mode;
  logic                  o_osc_pin_one_gpio_en;
  int                    err_total = 0;
  int                    n_tests = 0;
  always #5 i_core_clk = ~i_core_clk;
  irc_sel dut_u (
    .i_core_clk                 (i_core_clk),
    .i_sys_rst                  (i_sys_rst),
    .i_por_event                (i_por_event),
    .i_pwrup_expired            (i_pwrup_expired),
    .i_fail_monitor_en          (i_fail_monitor_en),
    .i_watchdog_en              (i_watchdog_en),
    .i_current_clock_source_sel (i_current_clock_source_sel),
    .i_primary_mode_config      (i_primary_mode_config),
    .i_trim_wr                  (i_trim_wr),
    .i_trim_wdata               (i_trim_wdata),
    .o_sysclk_from_fast_rc      (o_sysclk_from_fast_rc),
    .o_pll_en                   (o_pll_en),
    .o_pll_mult                 (o_pll_mult),
    .o_rc_trim_reg              (o_rc_trim_reg),
    .o_trim_offset_permil       (o_trim_offset_permil),
    .o_x16_trim_too_high        (o_x16_trim_too_high),
    .o_low_power_internal_rc_en (o_low_power_internal_rc_en),
    .o_timers_on_low_power_rc   (o_timers_on_low_power_rc),
    .o_osc_pin_two_mode         (o_osc_pin_two_mode),
    .o_osc_pin_one_gpio_en      (o_osc_pin_one_gpio_en)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Inputs move on the falling edge, so one step lands exactly one rising edge
  task automatic step();
    @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : step
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic trim_write(input logic [3:0] code, input logic por);
    i_trim_wr = 1'b1;
    i_trim_wdata = code;
    i_por_event = por;
    step();
  endtask : trim_write
  // The strobe stays high after a write so back-to-back writes never drop
  // and raise it in one time step; the caller releases it when done
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin : watchdog_timer
    #20000;
    err_total++;
    end_of_test();
  end
  initial begin : main_seq
    logic [2:0] sels [4];
    logic [4:0] mult;
    int         off;
    sels = '{SEL_FAST_RC, SEL_PRIMARY_PLL, SEL_LOW_POWER_RC, 3'h0};
    repeat (6) @(negedge i_core_clk);
    chk("trim_rst", {4'h0, o_rc_trim_reg}, {4'h0, TRIM_RESET});
    chk("lp_rc_rst", {7'h0, o_low_power_internal_rc_en}, 8'h01);
    i_sys_rst = 1'b0;
    step();
    chk("timer_clk", {7'h0, o_timers_on_low_power_rc}, 8'h01);
    $display("Test reset done");
    // Walk four selection codes against modes 4 to 8, modes 4 and 8 either side of the x4-x16 codes as near misses
    foreach (sels[s]) begin
      for (int m = 4; m < 9; m++) begin
        i_current_clock_source_sel = sels[s];
        i_primary_mode_config = 5'(m);
        step();
        mult = (sels[s] != SEL_PRIMARY_PLL) ? PLL_MULT_NONE : (m == 5) ? PLL_MULT_X4 :
               (m == 6) ? PLL_MULT_X8 : (m == 7) ? PLL_MULT_X16 : PLL_MULT_NONE;
        chk("fast_rc", {7'h0, o_sysclk_from_fast_rc}, {7'h0, sels[s] == SEL_FAST_RC});
        chk("pll_mult", {3'h0, o_pll_mult}, {3'h0, mult});
        chk("pll_en", {7'h0, o_pll_en}, {7'h0, mult != PLL_MULT_NONE});
        chk("pin_two", {3'h0, o_osc_pin_two_mode}, 8'(m));
        chk("pin_one", {7'h0, o_osc_pin_one_gpio_en}, 8'h00);
      end
    end
    $display("Test selection done");
    // Every trim code back to back with x16 chosen, so the limit flag is exercised
    i_current_clock_source_sel = SEL_PRIMARY_PLL;
    i_primary_mode_config = PM_FAST_RC_X16;
    for (int c = 0; c < 16; c++) begin
      trim_write(4'(c), 1'b0);
      off = ((c > 7) ? c - 16 : c) * TRIM_STEP_PERMIL;
      chk("trim", {4'h0, o_rc_trim_reg}, 8'(c));
      chk("offset", o_trim_offset_permil, 8'(off));
      chk("x16_flag", {7'h0, o_x16_trim_too_high},
          {7'h0, FAST_RC_NOM_KHZ * (1000 + off) > X16_LIMIT_KHZ * 1000});
    end
    $display("Test trim done");
    // A write that meets a power-on event is dropped and the trim recentres
    i_current_clock_source_sel = 3'h0;
    trim_write(4'h3, 1'b1);
    chk("trim_por", {4'h0, o_rc_trim_reg}, {4'h0, TRIM_RESET});
    chk("lp_rc_hold", {7'h0, o_low_power_internal_rc_en}, 8'h01);
    i_trim_wr = 1'b0;
    i_por_event = 1'b0;
    i_pwrup_expired = 1'b1;
    step();
    chk("lp_rc_off", {7'h0, o_low_power_internal_rc_en}, 8'h00);
    step();
    chk("lp_rc_stays_off", {7'h0, o_low_power_internal_rc_en}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      i_fail_monitor_en = (k == 0);
      i_watchdog_en = (k == 1);
      i_current_clock_source_sel = (k == 2) ? SEL_LOW_POWER_RC : SEL_FAST_RC;
      step();
      chk("lp_rc_keep", {7'h0, o_low_power_internal_rc_en}, {7'h0, k < 3});
    end
    // A new power-on event forces the oscillator on again even with expiry still high
    i_por_event = 1'b1;
    step();
    chk("lp_rc_por", {7'h0, o_low_power_internal_rc_en}, 8'h01);
    i_por_event = 1'b0;
    i_pwrup_expired = 1'b0;
    step();
    chk("lp_rc_por_hold", {7'h0, o_low_power_internal_rc_en}, 8'h01);
    $display("Test low power rc done");
    end_of_test();
  end
endmodule : tb
